/* src/tpsc_pkg.sv */
// Package for the print and spacing control of a page printer typing unit.
// Assumes a single 40 MHz clock domain; used as tpsc_pkg::name everywhere.
package tpsc_pkg;
    localparam int CODE_W = 8;
    localparam int COL_W = 7;
    localparam logic [6:0] MAX_COLS = 7'h55;
    localparam logic [6:0] CUTOUT_COL = 7'h53;
    localparam logic [6:0] WARN_COL_DEF = 7'h4B;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    // Code bit n sits at vector index n-1
    localparam int BIT3 = 2;
    localparam int BIT6 = 5;
    localparam int BIT7 = 6;
    // Print cycle length in clocks and its reversal point
    localparam logic [3:0] PRINT_CYC = 4'h8;
    localparam logic [3:0] REVERSAL = 4'h4;
    // Spacing driver stops: three per revolution, one stop per trip
    localparam logic [1:0] SPACE_STOPS = 2'h3;
    localparam logic [1:0] SPACE_DWELL = 2'h2;

    typedef enum logic [1:0] {
        PR_IDLE = 2'b00,
        PR_RISE = 2'b01,
        PR_FALL = 2'b11
    } tpsc_print_t;

    typedef struct packed {
        logic print_run;
        logic blank;
        logic space_step;
        logic line_full;
        logic margin_warn;
    } tpsc_status_t;
endpackage

/* src/tpsc_space_drive.sv */
// Spacing driver: one trip advances one ratchet tooth, then halts at the next stop.
// Assumes trip pulses come from the print cycle controller on the same clock.
`timescale 1ns/10ps
`default_nettype none
module tpsc_space_drive (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trip,
    output logic busy,
    output logic step,
    output logic [1:0] stop_pos
);
    logic [1:0] cnt_q;
    logic [1:0] stop_q;
    logic step_q;
    wire logic running = (cnt_q != 2'h0);

    // Turns through one third of a revolution, then idles until tripped again
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 2'h0;
            stop_q <= 2'h0;
            step_q <= 1'b0;
        end else begin
            step_q <= 1'b0;
            if (!running && trip) begin
                cnt_q <= tpsc_pkg::SPACE_DWELL;
            end else if (running) begin
                cnt_q <= cnt_q - 2'h1;
                if (cnt_q == 2'h1) begin
                    step_q <= 1'b1;
                    stop_q <= (stop_q == tpsc_pkg::SPACE_STOPS - 2'h1) ? 2'h0 : stop_q + 2'h1;
                end
            end
        end
    end

    assign busy = running;
    assign step = step_q;
    assign stop_pos = stop_q;

    // Trip, two dwell clocks, then the step register shows one pulse
    a_drive_one_step: assert property (@(posedge clk) disable iff (!rst_n)
        (!running && trip) |-> ##3 step_q ##1 !step_q [*2])
        else $error("drive step count wrong");
    a_drive_halts: assert property (@(posedge clk) disable iff (!rst_n)
        step_q |-> !running)
        else $error("drive did not halt");
endmodule
`default_nettype wire

/* src/tpsc_print_space.sv */
// Top of the print and spacing control: decides print, spacing and the column.
// Assumes code word and trip come from a receiver on clk; trip is one cycle wide.
`timescale 1ns/10ps
`default_nettype none
module tpsc_print_space #(
    parameter logic [6:0] MAX_COLS = tpsc_pkg::MAX_COLS,
    parameter logic [6:0] CUTOUT_COL = tpsc_pkg::CUTOUT_COL
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] code_word,
    input wire logic char_trip,
    input wire logic func_space_suppress,
    input wire logic carriage_return,
    input wire logic [6:0] warn_col,
    output logic func_start,
    output logic [6:0] column,
    output tpsc_pkg::tpsc_status_t status
);
    if (MAX_COLS == 7'h00 || CUTOUT_COL > MAX_COLS) begin : g_bad_cols
        $error("tpsc_print_space: cutout column must lie within the line");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Print suppression decode
    // The auxiliary suppression bar is clipped out, so it is a constant zero
    wire logic aux_suppress = 1'b0;
    wire logic supp_67 = !code_word[tpsc_pkg::BIT6] && !code_word[tpsc_pkg::BIT7];
    wire logic supp_all = &code_word[tpsc_pkg::BIT7:tpsc_pkg::BIT3];
    wire logic print_ok = !(supp_67 || supp_all || aux_suppress);
    wire logic is_space = (code_word == tpsc_pkg::SPACE_CODE);

    ////////////////////////////////////////////////////////////////////////////
    // Print cycle
    tpsc_pkg::tpsc_print_t st_q, st_d;
    logic [3:0] ph_q;
    logic armed_q;
    logic blank_q;
    logic cutout_q;
    logic fsupp_q;
    logic [6:0] col_q;
    logic warn_q;
    logic fire_q;

    wire logic start = char_trip && (st_q == tpsc_pkg::PR_IDLE) && print_ok;
    wire logic at_rev = (st_q == tpsc_pkg::PR_RISE) && (ph_q == tpsc_pkg::REVERSAL - 4'h1);
    wire logic at_end = (st_q == tpsc_pkg::PR_FALL) && (ph_q == tpsc_pkg::PRINT_CYC - 4'h1);
    wire logic fire = at_rev && armed_q && !fsupp_q && !func_space_suppress && !cutout_q;
    wire logic step;
    wire logic drv_busy;

    always_comb begin
        st_d = st_q;
        case (st_q)
            tpsc_pkg::PR_IDLE: if (start) st_d = tpsc_pkg::PR_RISE;
            tpsc_pkg::PR_RISE: if (at_rev) st_d = tpsc_pkg::PR_FALL;
            tpsc_pkg::PR_FALL: if (at_end) st_d = tpsc_pkg::PR_IDLE;
            default: st_d = tpsc_pkg::PR_IDLE;
        endcase
    end

    // Function decode starts on every trip taken while the print cycle is idle, suppressed or not
    assign func_start = char_trip && (st_q == tpsc_pkg::PR_IDLE);

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= tpsc_pkg::PR_IDLE;
            ph_q <= 4'h0;
            armed_q <= 1'b0;
            blank_q <= 1'b0;
            fsupp_q <= 1'b0;
            fire_q <= 1'b0;
        end else begin
            st_q <= st_d;
            fire_q <= fire;
            ph_q <= (st_q == tpsc_pkg::PR_IDLE) ? 4'h0 : ph_q + 4'h1;
            if (start) begin
                armed_q <= 1'b1;
                blank_q <= is_space;
                fsupp_q <= func_space_suppress;
            end else begin
                if (func_space_suppress) fsupp_q <= 1'b1;
                if (at_rev) armed_q <= 1'b0;
            end
        end
    end
    // Suppressed cycles never arm, so no spacing step follows them

    tpsc_space_drive u_drive (
        .clk(clk),
        .rst_n(rst_n_q),
        .trip(fire_q),
        .busy(drv_busy),
        .step(step),
        .stop_pos()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Carriage column, right-limit cutout and margin warning
    // Return takes priority over a step arriving in the same cycle
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            col_q <= 7'h00;
            cutout_q <= 1'b0;
            warn_q <= 1'b0;
        end else begin
            warn_q <= (col_q >= warn_col);
            if (carriage_return) begin
                col_q <= 7'h00;
                cutout_q <= 1'b0;
            end else begin
                if (step && col_q < MAX_COLS) col_q <= col_q + 7'h01;
                if (col_q >= CUTOUT_COL) cutout_q <= 1'b1;
            end
        end
    end

    assign column = col_q;
    // One driver for the whole struct keeps each member on a single assignment
    assign status = '{
        print_run: (st_q != tpsc_pkg::PR_IDLE),
        blank: blank_q,
        space_step: step,
        line_full: (col_q == MAX_COLS),
        margin_warn: warn_q
    };

    ////////////////////////////////////////////////////////////////////////////
    // Suppression is decoded again from the raw bits in all but a_supp_nostep, so a slip in print_ok cannot hide
    a_supp_67: assert property (@(posedge clk) disable iff (!rst_n_q)
        (char_trip && !code_word[tpsc_pkg::BIT6] && !code_word[tpsc_pkg::BIT7]) |-> !start)
        else $error("print not suppressed 6/7");
    a_supp_marks: assert property (@(posedge clk) disable iff (!rst_n_q)
        (char_trip && (&code_word[tpsc_pkg::BIT7:tpsc_pkg::BIT3])) |-> !start)
        else $error("print not suppressed 3-7");
    a_print_go: assert property (@(posedge clk) disable iff (!rst_n_q)
        (char_trip && !status.print_run && (code_word[tpsc_pkg::BIT6] || code_word[tpsc_pkg::BIT7])
        && !(&code_word[tpsc_pkg::BIT7:tpsc_pkg::BIT3])) |=> status.print_run)
        else $error("print cycle did not start");
    a_print_len: assert property (@(posedge clk) disable iff (!rst_n_q)
        start |=> status.print_run [*8] ##1 !status.print_run)
        else $error("print cycle length wrong");
    a_supp_quiet: assert property (@(posedge clk) disable iff (!rst_n_q)
        (char_trip && !status.print_run && ((!code_word[tpsc_pkg::BIT6] && !code_word[tpsc_pkg::BIT7])
        || (&code_word[tpsc_pkg::BIT7:tpsc_pkg::BIT3]))) |=> !step [*8])
        else $error("suppressed cycle spaced");
    a_supp_nostep: assert property (@(posedge clk) disable iff (!rst_n_q)
        (char_trip && !status.print_run && !print_ok) |=> !armed_q)
        else $error("suppressed cycle armed");
    a_fire_at_rev: assert property (@(posedge clk) disable iff (!rst_n_q)
        start |-> ##4 (fire || func_space_suppress || fsupp_q || cutout_q))
        else $error("spacing not fired at reversal");
    a_no_early_fire: assert property (@(posedge clk) disable iff (!rst_n_q)
        start |=> !fire [*3])
        else $error("spacing fired before reversal");
    a_fire_once: assert property (@(posedge clk) disable iff (!rst_n_q)
        fire |=> !fire [*8])
        else $error("spacing fired twice in a cycle");
    a_step_follows: assert property (@(posedge clk) disable iff (!rst_n_q)
        fire |-> ##4 step)
        else $error("fire gave no step");
    a_one_step: assert property (@(posedge clk) disable iff (!rst_n_q)
        step |=> !step [*8])
        else $error("more than one step per cycle");
    a_drive_idle: assert property (@(posedge clk) disable iff (!rst_n_q)
        fire_q |-> !drv_busy)
        else $error("spacing trip lost on busy drive");
    a_col_one: assert property (@(posedge clk) disable iff (!rst_n_q)
        (step && !carriage_return && col_q < MAX_COLS) |=> col_q == $past(col_q) + 7'h01)
        else $error("column not +1");
    a_col_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
        (!step && !carriage_return) |=> $stable(col_q))
        else $error("column moved without a step");
    a_col_limit: assert property (@(posedge clk) disable iff (!rst_n_q)
        col_q <= MAX_COLS)
        else $error("column past limit");
    a_blank_space: assert property (@(posedge clk) disable iff (!rst_n_q)
        (start && code_word == tpsc_pkg::SPACE_CODE) |=> status.blank)
        else $error("space code not blank");
    a_blank_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
        (start && code_word != tpsc_pkg::SPACE_CODE) |=> !status.blank)
        else $error("printing code marked blank");
    a_cutout: assert property (@(posedge clk) disable iff (!rst_n_q)
        (cutout_q && !carriage_return) |=> $stable(col_q))
        else $error("spacing past cutout");
    a_cutout_set: assert property (@(posedge clk) disable iff (!rst_n_q)
        (col_q >= CUTOUT_COL && !carriage_return) |=> cutout_q)
        else $error("cutout not latched");
    a_fsupp: assert property (@(posedge clk) disable iff (!rst_n_q)
        (func_space_suppress && st_q == tpsc_pkg::PR_RISE) |=> !step [*8])
        else $error("function did not inhibit space");
    a_cr_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
        carriage_return |=> (col_q == 7'h00 && !cutout_q))
        else $error("return did not clear");
    a_warn: assert property (@(posedge clk) disable iff (!rst_n_q)
        (col_q >= warn_col && $stable(warn_col)) |=> warn_q)
        else $error("margin warning missing");
    a_warn_off: assert property (@(posedge clk) disable iff (!rst_n_q)
        (col_q < warn_col && $stable(warn_col)) |=> !warn_q)
        else $error("margin warning early");
endmodule
`default_nettype wire

/* verif/tpsc_rx_model.sv */
// Code receiver model: hands one code word per character cycle to the print control.
// Assumes the bench calls send only while the print cycle is idle.
`timescale 1ns/10ps
`default_nettype none
module tpsc_rx_model (
    input wire logic clk,
    input wire logic func_start,
    output logic [7:0] code_word,
    output logic char_trip
);
    logic fs_seen;
    initial begin
        code_word = 8'h00;
        char_trip = 1'b0;
        fs_seen = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Word held through the whole print cycle, then inverted so a stale copy cannot pass
    task automatic send(input logic [7:0] c);
        @(negedge clk);
        code_word = c;
        char_trip = 1'b1;
        #1 fs_seen = func_start;
        @(negedge clk);
        char_trip = 1'b0;
        repeat (13) @(negedge clk);
        code_word = ~c;
    endtask
endmodule
`default_nettype wire

/* verif/tpsc_print_space_tb_top.sv */
// Self-checking bench for the print and spacing control.
// Assumes the receiver model drives code and trip; all else is driven here.
`timescale 1ns/10ps
`default_nettype none
module tpsc_print_space_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic fsup = 1'b0;
    logic cr = 1'b0;
    logic [6:0] warn_col = tpsc_pkg::WARN_COL_DEF;
    logic [7:0] code_word;
    logic char_trip;
    logic func_start;
    logic [6:0] column;
    tpsc_pkg::tpsc_status_t status;
    int fail_count = 0;
    int num_checks = 0;
    int steps = 0;
    initial forever #12.5 clk = ~clk;
    tpsc_rx_model u_rx (.clk(clk), .func_start(func_start), .code_word(code_word), .char_trip(char_trip));
    tpsc_print_space u_dut (.clk(clk), .reset_n(reset_n), .code_word(code_word), .char_trip(char_trip),
        .func_space_suppress(fsup), .carriage_return(cr), .warn_col(warn_col), .func_start(func_start),
        .column(column), .status(status));
    always @(negedge clk) if (status.space_step === 1'b1) steps++;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    // One character cycle; a late suppress pulse lands inside the trip-to-reversal span
    task automatic do_char(input logic [7:0] c, input logic sup, input logic [7:0] exp_step,
        input logic [6:0] exp_col);
        int s0;
        int i;
        s0 = steps;
        fork
            u_rx.send(c);
            if (sup) begin
                repeat (2) @(negedge clk);
                fsup = 1'b1;
                @(negedge clk);
                fsup = 1'b0;
            end
        join
        i = 0;
        while (status.print_run !== 1'b0 && i < 40) begin
            @(negedge clk);
            i++;
        end
        if (i == 40) begin
            fail_count++;
            end_sim();
        end
        chk("func_start", 8'h01, {7'h00, u_rx.fs_seen});
        chk("steps", exp_step, 8'(steps - s0));
        chk("column", {1'b0, exp_col}, {1'b0, column});
    endtask
    task automatic do_cr();
        @(negedge clk);
        cr = 1'b1;
        @(negedge clk);
        cr = 1'b0;
        @(negedge clk);
        chk("column", 8'h00, {1'b0, column});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_print();
        do_char(8'h41, 1'b0, 8'h01, 7'h01);
        do_char(8'h3C, 1'b0, 8'h01, 7'h02);
        do_char(8'h5C, 1'b0, 8'h01, 7'h03);
        $display("test print done");
    endtask
    task automatic t_suppress();
        do_char(8'h1F, 1'b0, 8'h00, 7'h03);
        do_char(8'h00, 1'b0, 8'h00, 7'h03);
        do_char(8'h7C, 1'b0, 8'h00, 7'h03);
        do_char(8'hFF, 1'b0, 8'h00, 7'h03);
        $display("test suppress done");
    endtask
    task automatic t_space();
        do_char(tpsc_pkg::SPACE_CODE, 1'b0, 8'h01, 7'h04);
        chk("blank", 8'h01, {7'h00, status.blank});
        do_char(8'h41, 1'b0, 8'h01, 7'h05);
        chk("blank", 8'h00, {7'h00, status.blank});
        $display("test space done");
    endtask
    task automatic t_fsup();
        do_char(8'h41, 1'b1, 8'h00, 7'h05);
        do_char(8'h41, 1'b0, 8'h01, 7'h06);
        $display("test function suppress done");
    endtask
    task automatic t_limit();
        logic [6:0] e;
        do_cr();
        for (int k = 1; k <= 88; k++) begin
            e = (k <= 83) ? 7'(k) : tpsc_pkg::CUTOUT_COL;
            do_char(8'h41, 1'b0, (k <= 83) ? 8'h01 : 8'h00, e);
            chk("margin_warn", {7'h00, e >= warn_col}, {7'h00, status.margin_warn});
        end
        chk("line_full", 8'h00, {7'h00, status.line_full});
        do_cr();
        do_char(8'h41, 1'b0, 8'h01, 7'h01);
        chk("margin_warn", 8'h00, {7'h00, status.margin_warn});
        $display("test line limit done");
    endtask
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        t_print();
        t_suppress();
        t_space();
        t_fsup();
        warn_col = 7'h50;
        t_limit();
        end_sim();
    end
endmodule
`default_nettype wire
